// File: design/clock_divider.sv
// programmable divider of a sampled clock level, factor field+1
// assumes: the clock to divide is sampled as a level on aclk
`timescale 1ns/1ps
`default_nettype none
module clock_divider #(
  parameter int width = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_level,
  input wire logic [width-1:0] factor_minus_one,
  output logic clk_out
);
  logic prev_level;
  logic [width:0] count;
  logic [width:0] half_count;
  wire rise = clk_level & ~prev_level;
  wire unity = (factor_minus_one == '0);
  // factor n: out high for the first ceil(n/2) input periods of each n
  // rounding up keeps the longer half high for odd factors
  assign half_count = ({1'b0, factor_minus_one} + (width+1)'(2)) >> 1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_level <= 1'b0;
      count <= '0;
      clk_out <= 1'b0;
    end else begin
      prev_level <= clk_level;
      if (unity) begin
        clk_out <= clk_level;
        count <= '0;
      end else if (rise) begin
        if (count >= {1'b0, factor_minus_one}) count <= '0;
        else count <= count + (width+1)'(1);
        clk_out <= (count >= {1'b0, factor_minus_one}) | (count + (width+1)'(1) < half_count);
      end
    end
  end
endmodule : clock_divider
`default_nettype wire

// File: design/system_clock_source_select.sv
// system clock source selector with AXI4-Lite control registers
// assumes: input clocks arrive as synchronous levels; the loop output is external
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - code 11 routes the direct clock input pin straight to the system clock
// - direct drive keeps frequency and duty cycle of the input
// - code 10 with bypass set divides oscillator by prescale field plus one
// - prescale factor one passes oscillator with its own duty cycle
// - prescale field reaches division by 1024
// - code 00 runs the system clock from the wakeup clock undivided
// - code 10 with bypass clear takes the external loop output
module system_clock_source_select
  import clock_select_pkg::*;
#(
  parameter int prescale_bits = prescale_width
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic direct_clock_input_pin,
  input wire logic crystal_input_pin,
  input wire logic internal_clock,
  input wire logic use_internal_clock,
  input wire logic wakeup_clock,
  input wire logic loop_clock,
  output logic sys_clock,
  output logic [3:0] loop_input_divide_field,
  output logic [7:0] loop_multiply_field,
  output logic [6:0] loop_output_divide_field,
  output logic loop_enable,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0] system_control_word_zero;
  logic [31:0] loop_control_word_zero;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] result;
    result = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) result[i*8 +: 8] = data[i*8 +: 8];
    end
    return result;
  endfunction : merge

  function automatic logic known_offset(input logic [7:0] addr);
    return addr == system_control_word_zero_offset || addr == loop_control_word_zero_offset ||
           addr == clock_status_offset;
  endfunction : known_offset

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  wire [1:0] sys_clock_source_code = system_control_word_zero[source_code_lsb +: source_code_width];
  wire oscillator_loop_bypass = loop_control_word_zero[bypass_pos];
  wire [prescale_bits-1:0] output_prescale_field =
    loop_control_word_zero[prescale_lsb +: prescale_bits];
  wire osc_level = use_internal_clock ? internal_clock : crystal_input_pin;
  wire divided_osc;
  wire source_is_direct = sys_clock_source_code == src_direct;
  wire source_is_loop = sys_clock_source_code == src_loop;
  wire source_is_wakeup = sys_clock_source_code == src_wakeup;
  wire next_sys_clock = source_is_direct ? direct_clock_input_pin :
                        source_is_loop & oscillator_loop_bypass ? divided_osc :
                        source_is_loop ? loop_clock :
                        source_is_wakeup ? wakeup_clock : 1'b0;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire [31:0] status_word = {27'h0, source_is_loop & ~oscillator_loop_bypass,
                             sys_clock, sys_clock_source_code, oscillator_loop_bypass};
  wire [31:0] next_rdata =
    s_axi_araddr == system_control_word_zero_offset ? system_control_word_zero :
    s_axi_araddr == loop_control_word_zero_offset ? loop_control_word_zero :
    s_axi_araddr == clock_status_offset ? status_word : 32'h0;

  // ------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------
  // field of 10 bits gives factors 1 to 1024
  clock_divider #(.width(prescale_bits)) prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_level(osc_level),
    .factor_minus_one(output_prescale_field),
    .clk_out(divided_osc)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clock <= 1'b0;
      loop_enable <= 1'b0;
      loop_input_divide_field <= 4'h0;
      loop_multiply_field <= 8'h00;
      loop_output_divide_field <= 7'h00;
    end else begin
      sys_clock <= next_sys_clock;
      // loop runs only while it sources the clock, saving power otherwise
      loop_enable <= source_is_loop & ~oscillator_loop_bypass;
      loop_input_divide_field <= loop_control_word_zero[loop_input_lsb +: loop_input_width];
      loop_multiply_field <= loop_control_word_zero[loop_multiply_lsb +: loop_multiply_width];
      loop_output_divide_field <= loop_control_word_zero[loop_output_lsb +: loop_output_width];
    end
  end

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= axi_okay;
      system_control_word_zero <= system_control_reset;
      loop_control_word_zero <= loop_control_reset;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known_offset(aw_addr) ? axi_okay : axi_slverr;
        if (aw_addr == system_control_word_zero_offset)
          system_control_word_zero <= merge(system_control_word_zero, w_data, w_strb) & 32'h3;
        if (aw_addr == loop_control_word_zero_offset)
          loop_control_word_zero <= merge(loop_control_word_zero, w_data, w_strb) & 32'h3fff_ffff;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= axi_okay;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= known_offset(s_axi_araddr) ? axi_okay : axi_slverr;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : system_clock_source_select
`default_nettype wire

// File: shared/clock_select_pkg.sv
// constants for the system clock source selector
// assumes: one 250 MHz bus clock, AXI4-Lite register access
package clock_select_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] system_control_word_zero_offset = 8'h00;
  localparam logic [7:0] loop_control_word_zero_offset = 8'h04;
  localparam logic [7:0] clock_status_offset = 8'h08;
  // ------------------------------------------------------------
  // fields
  // ------------------------------------------------------------
  localparam int source_code_lsb = 0;
  localparam int source_code_width = 2;
  localparam int bypass_pos = 0;
  localparam int prescale_lsb = 1;
  localparam int prescale_width = 10;
  localparam int loop_input_lsb = 11;
  localparam int loop_input_width = 4;
  localparam int loop_multiply_lsb = 15;
  localparam int loop_multiply_width = 8;
  localparam int loop_output_lsb = 23;
  localparam int loop_output_width = 7;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] system_control_reset = 32'h0000_0000;
  localparam logic [31:0] loop_control_reset = 32'h0000_0001;
  // ------------------------------------------------------------
  // source codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    src_wakeup = 2'b00,
    src_reserved = 2'b01,
    src_loop = 2'b10,
    src_direct = 2'b11
  } source_t;
  localparam logic [1:0] axi_okay = 2'b00;
  localparam logic [1:0] axi_slverr = 2'b10;
endpackage : clock_select_pkg

// File: testbench/clock_source_model.sv
// free running clock levels standing in for the external sources
// assumes: levels change just after the bus clock edge
`timescale 1ns/1ps
`default_nettype none
module clock_source_model (
  input wire logic aclk,
  output logic direct_clk,
  output logic osc_clk,
  output logic int_clk,
  output logic wake_clk,
  output logic loop_clk
);
  int n = 0;
  // uneven duty cycles on the direct and wakeup clocks, so a lost duty cycle shows
  always @(posedge aclk) n <= n + 1;
  assign direct_clk = (n % 6) < 2;
  assign osc_clk = (n % 4) < 2;
  assign int_clk = (n % 6) < 3;
  assign wake_clk = (n % 10) < 3;
  assign loop_clk = (n % 2) == 0;
endmodule : clock_source_model
`default_nettype wire

// File: testbench/system_clock_source_select_props.sv
// port assertions for the clock source selector, bound to every instance
// assumes: full-word writes; the control words are shadowed from the bus
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select_props
  import clock_select_pkg::*;
#(
  parameter int prescale_bits = prescale_width
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic direct_clock_input_pin,
  input wire logic crystal_input_pin,
  input wire logic internal_clock,
  input wire logic use_internal_clock,
  input wire logic wakeup_clock,
  input wire logic loop_clock,
  input wire logic sys_clock,
  input wire logic loop_enable,
  input wire logic [7:0] loop_multiply_field,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid
);
  // ---
  // shadow words; checks wait eight cycles after any change
  // ---
  logic [7:0] wa, calm;
  logic [31:0] wd, sysw, loopw;
  logic [1:0] rises;
  logic [11:0] oscs;
  logic osc_q, sys_q, bv_q, ui_q;
  wire osc = use_internal_clock ? internal_clock : crystal_input_pin;
  wire quiet = calm > 8'h07;
  wire [1:0] code = sysw[1:0];
  wire [11:0] k = {2'h0, loopw[10:1]} + 12'h001;
  wire sys_rise = sys_clock && !sys_q;
  wire upd = s_axi_bvalid && !bv_q && s_axi_bresp == axi_okay;
  wire chg = (s_axi_bvalid && !bv_q) || use_internal_clock != ui_q || !aresetn;
  always_ff @(posedge aclk) begin
    {osc_q, sys_q, bv_q, ui_q} <= {osc, sys_clock, s_axi_bvalid, use_internal_clock};
    if (s_axi_wvalid && s_axi_wready) {wa, wd} <= {s_axi_awaddr, s_axi_wdata};
    calm <= chg ? 8'h00 : calm + 8'(!quiet);
    rises <= chg ? 2'h0 : rises + 2'(sys_rise && rises != 2'h3);
    oscs <= sys_rise ? 12'h000 : oscs + 12'(osc && !osc_q);
    if (!aresetn) sysw <= system_control_reset;
    else if (upd && wa == system_control_word_zero_offset) sysw <= wd;
    if (!aresetn) loopw <= loop_control_reset;
    else if (upd && wa == loop_control_word_zero_offset) loopw <= wd;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_direct_follow: assert property (quiet && code == 2'h3
    |-> sys_clock == $past(direct_clock_input_pin)) else $error("direct input not followed");
  chk_wakeup_follow: assert property (quiet && code == 2'h0
    |-> sys_clock == $past(wakeup_clock)) else $error("wakeup clock not followed");
  chk_unity_pass: assert property (quiet && code == 2'h2 && loopw[0] && k == 12'h001
    |-> sys_clock == $past(osc, 2)) else $error("factor one does not pass the oscillator");
  chk_prescale_count: assert property (quiet && rises == 2'h3 && sys_rise && code == 2'h2
    && loopw[0] |-> oscs == k) else $error("prescaled period wrong");
  chk_loop_follow: assert property (quiet && loop_enable
    |-> sys_clock == $past(loop_clock)) else $error("loop output not followed");
  chk_loop_enable: assert property (quiet
    |-> loop_enable == (code == 2'h2 && !loopw[0])) else $error("loop enable wrong");
  chk_loop_fields: assert property (quiet
    |-> loop_multiply_field == loopw[22:15]) else $error("multiply field not exported");
  cov_direct: cover property (quiet && code == 2'h3);
  cov_max_div: cover property (quiet && sys_rise && k == 12'h400);
  cov_loop: cover property (quiet && loop_enable);
endmodule : system_clock_source_select_props
bind system_clock_source_select system_clock_source_select_props
  #(.prescale_bits(prescale_bits)) props (.*);
`default_nettype wire

// File: testbench/tb_system_clock_source_select.sv
// self-checking bench for the system clock source selector
// assumes: the source model drives the clock pins; the bench is bus master
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_source_select
  import clock_select_pkg::*;
;
  typedef struct packed {
    logic [31:0] sysw;
    logic [31:0] loopw;
    logic use_int;
    logic [31:0] per;
    logic [31:0] hi;
  } row_t;
  row_t rows [6] = '{'{32'h3, 32'h1, 1'b0, 32'h6, 32'h2}, '{32'h0, 32'h1, 1'b0, 32'ha, 32'h3},
    '{32'h2, 32'h1, 1'b0, 32'h4, 32'h2}, '{32'h2, 32'h5, 1'b1, 32'h12, 32'hc},
    '{32'h2, 32'h7ff, 1'b0, 32'h1000, 32'h800}, '{32'h2, 32'h2891800, 1'b0, 32'h2, 32'h1}};
  logic aclk = 1'b0, aresetn = 1'b0, use_internal_clock = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, lmul;
  logic [31:0] wdata = 32'h0, rdata, d, per, hi;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dclk, oclk, iclk, wclk, lclk, sys_clock;
  logic loop_enable;
  logic [1:0] bresp, rresp, r;
  logic [3:0] lin;
  logic [6:0] lout;
  int bad_count = 0, comparisons = 0, cyc = 0;
  clock_source_model src (.aclk(aclk), .direct_clk(dclk), .osc_clk(oclk), .int_clk(iclk),
    .wake_clk(wclk), .loop_clk(lclk));
  system_clock_source_select dut (.aclk(aclk), .aresetn(aresetn), .direct_clock_input_pin(dclk),
    .crystal_input_pin(oclk), .internal_clock(iclk), .use_internal_clock(use_internal_clock),
    .wakeup_clock(wclk), .loop_clock(lclk), .sys_clock(sys_clock), .loop_enable(loop_enable),
    .loop_input_divide_field(lin), .loop_multiply_field(lmul), .loop_output_divide_field(lout),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ---
  // bus cycles, measurement and reporting
  // ---
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask : rd
  // one full period of the system clock, counted in bus clock cycles
  task measure();
    while (sys_clock !== 1'b0) @(posedge aclk);
    while (sys_clock !== 1'b1) @(posedge aclk);
    hi = 32'h0;
    while (sys_clock === 1'b1) begin
      @(posedge aclk);
      hi = hi + 32'h1;
    end
    per = hi;
    while (sys_clock !== 1'b1) begin
      @(posedge aclk);
      per = per + 32'h1;
    end
  endtask : measure
  task stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      use_internal_clock <= rows[i].use_int;
      wr(system_control_word_zero_offset, rows[i].sysw);
      wr(loop_control_word_zero_offset, rows[i].loopw);
      // first period may straddle the switch
      measure();
      measure();
      check("period", per, rows[i].per);
      check("high time", hi, rows[i].hi);
      check("write response", {30'h0, r}, {30'h0, axi_okay});
      $display("row %0d done", i);
    end
    check("loop fields", {13'h0, lin, lmul, lout}, 32'h18905);
    check("loop enable", {31'h0, loop_enable}, 32'h1);
    rd(clock_status_offset);
    check("status", d & 32'h17, 32'h14);
    wr(8'h0c, 32'h3);
    check("unmapped write", {30'h0, r}, {30'h0, axi_slverr});
    rd(8'h0c);
    check("unmapped read", {d[29:0], r}, {30'h0, axi_slverr});
    $display("unmapped done");
    // reserved source code parks the system clock low
    wr(system_control_word_zero_offset, 32'h1);
    repeat (4) @(posedge aclk);
    check("reserved code", {31'h0, sys_clock}, 32'h0);
    $display("reserved done");
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    check("clock in reset", {31'h0, sys_clock}, 32'h0);
    aresetn <= 1'b1;
    rd(system_control_word_zero_offset);
    check("control reset", d, system_control_reset);
    rd(loop_control_word_zero_offset);
    check("loop reset", d, loop_control_reset);
    check("read response", {30'h0, r}, {30'h0, axi_okay});
    $display("reset done");
    stop_test();
  end
endmodule : tb_system_clock_source_select
`default_nettype wire
